/* include/dhrs_pkg.sv */
// Package: constants and types of the display hardware reset sequencer
package dhrs_pkg;

  // ****************************************************
  // Clock
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ****************************************************
  // Reset pin filter
  // ****************************************************
  localparam int unsigned REJECT_TIME_NS = 5000;
  localparam int unsigned FULL_TIME_NS   = 9000;
  localparam int unsigned GLITCH_TIME_NS = 20;
  // Least times: round up
  localparam int unsigned ACCEPT_CYC =
    (REJECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FULL_CYC =
    (FULL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************
  // Cancel, blanking and command windows
  // ****************************************************
  localparam int unsigned CANCEL_IN_US   = 5000;
  localparam int unsigned CANCEL_OUT_US  = 120000;
  localparam int unsigned BLANK_MAX_US   = 120000;
  localparam int unsigned SLPOUT_WAIT_US = 120000;
  // Longest times: round down
  localparam int unsigned CANCEL_IN_CYC  = CANCEL_IN_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CANCEL_OUT_CYC = CANCEL_OUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC      = BLANK_MAX_US * 1000 / CLK_PERIOD_NS;
  // Least time: round up
  localparam int unsigned SLPOUT_WAIT_CYC =
    (SLPOUT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************
  // Stored settings
  // ****************************************************
  localparam int unsigned OTP_WORDS   = 5;
  localparam int unsigned IDX_ID0     = 0;
  localparam int unsigned IDX_ID1     = 1;
  localparam int unsigned IDX_ID2     = 2;
  localparam int unsigned IDX_COMELEC = 3;
  localparam int unsigned IDX_OTHER   = 4;
  localparam logic [7:0]  SET_DEFAULT = 8'h00;

  // ****************************************************
  // Types
  // ****************************************************
  typedef logic [23:0] dhrs_tmr_t;
  typedef logic [9:0]  dhrs_low_t;
  typedef logic [1:0]  dhrs_hi_t;
  typedef logic [2:0]  dhrs_idx_t;
  typedef logic [7:0]  dhrs_byte_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_LOAD = 2'b01,
    ST_WAIT = 2'b10,
    ST_RUN  = 2'b11
  } dhrs_state_t;

endpackage

/* rtl/dhrs_reset_seq.sv */
// Module: hardware reset filter, settings load and cancel sequencer
`timescale 1ns/1ps
module dhrs_reset_seq #(
  parameter int unsigned CANCEL_IN_CYC  = dhrs_pkg::CANCEL_IN_CYC,
  parameter int unsigned CANCEL_OUT_CYC = dhrs_pkg::CANCEL_OUT_CYC,
  parameter int unsigned BLANK_CYC      = dhrs_pkg::BLANK_CYC,
  parameter int unsigned SLPOUT_CYC     = dhrs_pkg::SLPOUT_WAIT_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Reset pin and mode
  input  wire logic               hwResetN,
  input  wire logic               sleepOutMode,
  // Settings memory read port
  output logic                    otpRdEn,
  output dhrs_pkg::dhrs_idx_t     otpAddr,
  input  wire dhrs_pkg::dhrs_byte_t otpRdData,
  input  wire logic               otpRdValid,
  // Core status
  output logic                    coreResetN,
  output logic                    cmdReady,
  output logic                    sleepOutOk,
  output logic                    displayBlank,
  output logic                    blankSeqActive,
  output logic                    otpFault,
  // Loaded settings
  output dhrs_pkg::dhrs_byte_t    idByte0,
  output dhrs_pkg::dhrs_byte_t    idByte1,
  output dhrs_pkg::dhrs_byte_t    idByte2,
  output dhrs_pkg::dhrs_byte_t    commonElectrodeSetting,
  output dhrs_pkg::dhrs_byte_t    otherSetting
);

  // ****************************************************
  // Functions
  // ****************************************************
  function automatic dhrs_pkg::dhrs_tmr_t satInc(
    input dhrs_pkg::dhrs_tmr_t v
  );
    satInc = (&v) ? v : v + dhrs_pkg::dhrs_tmr_t'(1);
  endfunction

  function automatic dhrs_pkg::dhrs_tmr_t cancelLast(input logic wasOut);
    cancelLast = wasOut ? dhrs_pkg::dhrs_tmr_t'(CANCEL_OUT_CYC - 1)
                        : dhrs_pkg::dhrs_tmr_t'(CANCEL_IN_CYC - 1);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  dhrs_pkg::dhrs_state_t st_r;
  dhrs_pkg::dhrs_state_t st_nxt;
  dhrs_pkg::dhrs_hi_t    highCnt_r;
  dhrs_pkg::dhrs_low_t   lowCnt_r;
  dhrs_pkg::dhrs_tmr_t   tmr_r;
  dhrs_pkg::dhrs_tmr_t   blkCnt_r;
  logic                  blkBusy_r;
  logic                  wasOut_r;
  logic                  otpFault_r;
  dhrs_pkg::dhrs_idx_t   otpIdx_r;
  dhrs_pkg::dhrs_byte_t  mem_r [dhrs_pkg::OTP_WORDS];

  // ****************************************************
  // Pin filter
  // ****************************************************
  localparam dhrs_pkg::dhrs_hi_t  HI_FULL =
    dhrs_pkg::dhrs_hi_t'(dhrs_pkg::GLITCH_CYC);
  localparam dhrs_pkg::dhrs_low_t LOW_LAST =
    dhrs_pkg::dhrs_low_t'(dhrs_pkg::ACCEPT_CYC);

  wire filtHigh  = (highCnt_r == HI_FULL);
  wire rstAccept = !filtHigh && (lowCnt_r == LOW_LAST);
  wire enterHold = rstAccept && (st_r != dhrs_pkg::ST_HOLD);
  wire dhrs_pkg::dhrs_hi_t highCnt_nxt =
    !hwResetN ? '0 : (filtHigh ? highCnt_r : highCnt_r + 2'h1);
  wire dhrs_pkg::dhrs_low_t lowCnt_nxt =
    filtHigh ? '0 : (rstAccept ? lowCnt_r : lowCnt_r + 10'h001);

  // ****************************************************
  // Sequencing decode
  // ****************************************************
  wire timeUp   = (tmr_r == cancelLast(wasOut_r));
  wire lastWord = (otpIdx_r ==
                   dhrs_pkg::dhrs_idx_t'(dhrs_pkg::OTP_WORDS - 1));
  wire loadLast = (st_r == dhrs_pkg::ST_LOAD) && otpRdValid && lastWord;
  wire loadStep = (st_r == dhrs_pkg::ST_LOAD) && otpRdValid;
  wire blkLast  = (blkCnt_r == dhrs_pkg::dhrs_tmr_t'(BLANK_CYC - 1));
  wire blkStart = enterHold && sleepOutMode;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      dhrs_pkg::ST_HOLD:
        if (filtHigh)
          st_nxt = dhrs_pkg::ST_LOAD;
      dhrs_pkg::ST_LOAD:
        if (enterHold)
          st_nxt = dhrs_pkg::ST_HOLD;
        else if (timeUp)
          st_nxt = dhrs_pkg::ST_RUN;
        else if (loadLast)
          st_nxt = dhrs_pkg::ST_WAIT;
      dhrs_pkg::ST_WAIT:
        if (enterHold)
          st_nxt = dhrs_pkg::ST_HOLD;
        else if (!blkBusy_r || timeUp)
          st_nxt = dhrs_pkg::ST_RUN;
      dhrs_pkg::ST_RUN:
        if (enterHold)
          st_nxt = dhrs_pkg::ST_HOLD;
      default:
        st_nxt = dhrs_pkg::ST_HOLD;
    endcase
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r      <= dhrs_pkg::ST_HOLD;
      highCnt_r <= '0;
      lowCnt_r  <= '0;
    end
    else
    begin
      st_r      <= st_nxt;
      highCnt_r <= highCnt_nxt;
      lowCnt_r  <= lowCnt_nxt;
    end
  end

  // Cancel timer runs on past RUN so sleep-out wait is measurable
  always_ff @(posedge clk)
  begin
    if (!nrst || st_r == dhrs_pkg::ST_HOLD)
      tmr_r <= '0;
    else
      tmr_r <= satInc(tmr_r);
  end

  // Mode is caught once, when the reset is accepted
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wasOut_r <= 1'b0;
    else if (enterHold)
      wasOut_r <= sleepOutMode;
  end

  // Blanking keeps running across release; cancel covers its length
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      blkBusy_r <= 1'b0;
      blkCnt_r  <= '0;
    end
    else if (blkStart)
    begin
      blkBusy_r <= 1'b1;
      blkCnt_r  <= '0;
    end
    else if (blkBusy_r)
    begin
      blkBusy_r <= !blkLast;
      blkCnt_r  <= satInc(blkCnt_r);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || st_r == dhrs_pkg::ST_HOLD)
    begin
      otpIdx_r   <= '0;
      otpFault_r <= 1'b0;
    end
    else
    begin
      if (loadStep && !lastWord)
        otpIdx_r <= otpIdx_r + 3'h1;
      if (st_r == dhrs_pkg::ST_LOAD && timeUp && !loadLast)
        otpFault_r <= 1'b1;
    end
  end

  // Defaults while held, so a slow memory still leaves sane values
  always_ff @(posedge clk)
  begin
    if (!nrst || st_r == dhrs_pkg::ST_HOLD)
    begin
      for (int i = 0; i < dhrs_pkg::OTP_WORDS; i++)
        mem_r[i] <= dhrs_pkg::SET_DEFAULT;
    end
    else if (loadStep)
      mem_r[otpIdx_r] <= otpRdData;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign otpRdEn        = (st_r == dhrs_pkg::ST_LOAD);
  assign otpAddr        = otpIdx_r;
  assign coreResetN     = (st_r == dhrs_pkg::ST_RUN);
  assign cmdReady       = (st_r == dhrs_pkg::ST_RUN);
  assign sleepOutOk     = cmdReady &&
                          (tmr_r >= dhrs_pkg::dhrs_tmr_t'(SLPOUT_CYC));
  assign displayBlank   = (st_r != dhrs_pkg::ST_RUN) || blkBusy_r;
  assign blankSeqActive = blkBusy_r;
  assign otpFault       = otpFault_r;
  assign idByte0        = mem_r[dhrs_pkg::IDX_ID0];
  assign idByte1        = mem_r[dhrs_pkg::IDX_ID1];
  assign idByte2        = mem_r[dhrs_pkg::IDX_ID2];
  assign commonElectrodeSetting = mem_r[dhrs_pkg::IDX_COMELEC];
  assign otherSetting   = mem_r[dhrs_pkg::IDX_OTHER];

  // ****************************************************
  // Assertions
  // ****************************************************
  localparam int LOAD_LAT_MIN = 1;
  localparam int LOAD_LAT_MAX = 2;

  sequence seqGlitch;
    (st_r == dhrs_pkg::ST_HOLD) && !hwResetN ##1 hwResetN ##1 !hwResetN;
  endsequence

  sequence seqRelease;
    ((st_r == dhrs_pkg::ST_HOLD) && hwResetN) [*2];
  endsequence

  AST_GLITCH: assert property (@(posedge clk) disable iff (!nrst)
    seqGlitch |=> st_r == dhrs_pkg::ST_HOLD)
    else $error("Short high glitch ended reset");

  AST_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
    seqRelease |-> ##[LOAD_LAT_MIN:LOAD_LAT_MAX] st_r == dhrs_pkg::ST_LOAD)
    else $error("Release did not start settings load");

  AST_ACCEPT_AT: assert property (@(posedge clk) disable iff (!nrst)
    (st_r != dhrs_pkg::ST_HOLD) ##1 (st_r == dhrs_pkg::ST_HOLD) |->
      $past(lowCnt_r) == LOW_LAST)
    else $error("Reset entered at wrong pulse length");

  AST_ACCEPT_GO: assert property (@(posedge clk) disable iff (!nrst)
    enterHold |=> st_r == dhrs_pkg::ST_HOLD && !coreResetN)
    else $error("Accepted pulse did not reset");

  AST_LOAD_STORE: assert property (@(posedge clk) disable iff (!nrst)
    loadStep && !enterHold && !timeUp && otpIdx_r == 3'h3 |=>
      commonElectrodeSetting == $past(otpRdData))
    else $error("Common electrode setting not stored");

  AST_CANCEL_IN: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dhrs_pkg::ST_LOAD || st_r == dhrs_pkg::ST_WAIT) && !wasOut_r
      |-> tmr_r < dhrs_pkg::dhrs_tmr_t'(CANCEL_IN_CYC))
    else $error("Sleep-in cancel interval overran");

  AST_CANCEL_OUT: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dhrs_pkg::ST_LOAD || st_r == dhrs_pkg::ST_WAIT) && wasOut_r
      |-> tmr_r < dhrs_pkg::dhrs_tmr_t'(CANCEL_OUT_CYC))
    else $error("Sleep-out cancel interval overran");

  AST_BLANK_SEQ: assert property (@(posedge clk) disable iff (!nrst)
    blkBusy_r |-> blkCnt_r < dhrs_pkg::dhrs_tmr_t'(BLANK_CYC))
    else $error("Blanking sequence too long");

  AST_BLANK_START: assert property (@(posedge clk) disable iff (!nrst)
    blkStart |=> blankSeqActive && displayBlank)
    else $error("Blanking did not start in sleep-out");

  AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !coreResetN |-> displayBlank)
    else $error("Display not blank while resetting");

  AST_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
    $rose(coreResetN) |-> $past(st_r) != dhrs_pkg::ST_HOLD && cmdReady)
    else $error("Core released without full sequence");

  AST_CMD_GAP: assert property (@(posedge clk) disable iff (!nrst)
    sleepOutOk |-> cmdReady && tmr_r >= dhrs_pkg::dhrs_tmr_t'(SLPOUT_CYC))
    else $error("Sleep-out allowed too early");

endmodule // dhrs_reset_seq

/* tb/dhrs_otp_model.sv */
// Settings memory model answering the sequencer's read port
`timescale 1ns/1ps
module dhrs_otp_model (
  // Clock
  input  wire logic                 clk,
  // Read port
  input  wire logic                 otpRdEn,
  input  wire dhrs_pkg::dhrs_idx_t  otpAddr,
  output dhrs_pkg::dhrs_byte_t      otpRdData,
  output logic                      otpRdValid,
  // Behaviour
  input  wire dhrs_pkg::dhrs_byte_t base,
  input  wire logic [8:0]           lat
);
  logic [8:0] wait_r;

  initial
  begin
    otpRdValid = 1'b0;
    otpRdData  = 8'h5a;
    wait_r     = 9'h000;
  end

  always @(posedge clk)
  begin
    otpRdValid <= 1'b0;
    // Idle data toggles so a stale word never passes for a fresh one
    otpRdData  <= ~otpRdData;
    if (otpRdEn && !otpRdValid && wait_r >= lat)
    begin
      otpRdValid <= 1'b1;
      otpRdData  <= base ^ {5'h00, otpAddr};
      wait_r     <= 9'h000;
    end
    else if (otpRdEn && !otpRdValid)
      wait_r <= wait_r + 9'h001;
    else
      wait_r <= 9'h000;
  end
endmodule // dhrs_otp_model

/* tb/tb.sv */
// Testbench of the display hardware reset sequencer
`timescale 1ns/1ps
module tb;
  localparam int CIN  = 200;
  localparam int COUT = 400;
  localparam int BLK  = 300;
  localparam int SLP  = 350;
  typedef struct packed {logic [7:0] base; logic fault;} dhrs_exp_t;

  // ********
  // Signals
  // ********
  logic clk, nrst, hwResetN, sleepOutMode, otpRdEn, otpRdValid;
  logic coreResetN, cmdReady, sleepOutOk, displayBlank, blankSeqActive;
  logic otpFault, rdyLow, rdyLate, blankGap;
  dhrs_pkg::dhrs_idx_t  otpAddr;
  dhrs_pkg::dhrs_byte_t otpRdData, idByte0, idByte1, idByte2, base;
  dhrs_pkg::dhrs_byte_t commonElectrodeSetting, otherSetting;
  logic [8:0] lat;
  int         errors, check_count, blankCnt, waited;
  dhrs_exp_t  expQ[$];
  dhrs_exp_t  eNow;

  dhrs_reset_seq #(.CANCEL_IN_CYC(CIN), .CANCEL_OUT_CYC(COUT),
    .BLANK_CYC(BLK), .SLPOUT_CYC(SLP)) uut (
    .clk(clk), .nrst(nrst), .hwResetN(hwResetN),
    .sleepOutMode(sleepOutMode), .otpRdEn(otpRdEn), .otpAddr(otpAddr),
    .otpRdData(otpRdData), .otpRdValid(otpRdValid),
    .coreResetN(coreResetN), .cmdReady(cmdReady), .sleepOutOk(sleepOutOk),
    .displayBlank(displayBlank), .blankSeqActive(blankSeqActive),
    .otpFault(otpFault), .idByte0(idByte0), .idByte1(idByte1),
    .idByte2(idByte2), .commonElectrodeSetting(commonElectrodeSetting),
    .otherSetting(otherSetting));

  dhrs_otp_model mem (.clk(clk), .otpRdEn(otpRdEn), .otpAddr(otpAddr),
    .otpRdData(otpRdData), .otpRdValid(otpRdValid), .base(base), .lat(lat));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (blankSeqActive === 1'b1)
      blankCnt++;

  // ********
  // Checks
  // ********
  task automatic chk_bit(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test;
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [7:0] expw(input logic [7:0] i);
    return eNow.fault ? dhrs_pkg::SET_DEFAULT : eNow.base ^ i;
  endfunction

  // Each rise of cmdReady closes one cancel interval
  always @(posedge cmdReady)
  begin
    #1;
    if (expQ.size() == 0)
      chk_bit("expQ", 1'b1, 1'b0);
    else
    begin
      eNow = expQ.pop_front();
      chk_byte("idByte0", expw(8'h00), idByte0);
      chk_byte("idByte1", expw(8'h01), idByte1);
      chk_byte("idByte2", expw(8'h02), idByte2);
      chk_byte("comElec", expw(8'h03), commonElectrodeSetting);
      chk_byte("other", expw(8'h04), otherSetting);
      chk_bit("otpFault", eNow.fault, otpFault);
      chk_bit("coreResetN", 1'b1, coreResetN);
    end
  end

  // ********
  // Stimulus
  // ********
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int lowCyc, input int glitchAt);
    rdyLow  = 1'b0;
    rdyLate = 1'b0;
    for (int i = 0; i < lowCyc; i++)
    begin
      hwResetN = (i == glitchAt);
      step;
      if (cmdReady !== 1'b1)
        rdyLow = 1'b1;
      if (cmdReady !== 1'b0 && i > 520)
        rdyLate = 1'b1;
    end
    hwResetN = 1'b1;
  endtask

  // Host holds off until the device reports it is ready
  task automatic wait_ready(input int bound);
    waited   = 0;
    blankGap = 1'b0;
    while (cmdReady !== 1'b1)
    begin
      if (waited >= bound)
      begin
        chk_bit("cmdReady", 1'b1, cmdReady);
        finish_test;
      end
      if (displayBlank !== 1'b1)
        blankGap = 1'b1;
      step;
      waited++;
    end
  endtask

  initial
  begin
    nrst = 1'b0;
    hwResetN = 1'b1;
    sleepOutMode = 1'b0;
    base = 8'h13;
    lat = 9'h000;
    errors = 0;
    check_count = 0;
    blankCnt = 0;
    expQ.push_back('{base, 1'b0});
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    wait_ready(CIN + 4);
    pulse(499, -1);
    // Trailing high samples must not complete a short pulse
    repeat (4)
    begin
      step;
      if (cmdReady !== 1'b1)
        rdyLow = 1'b1;
    end
    chk_bit("shortPulse", 1'b0, rdyLow);
    base = lfsr(base);
    expQ.push_back('{base, 1'b0});
    pulse(1000, 700);
    chk_bit("fullReset", 1'b1, rdyLow);
    chk_bit("glitch", 1'b0, rdyLate);
    wait_ready(CIN + 4);
    chk_bit("blankHeld", 1'b0, blankGap);
    chk_bit("blankOff", 1'b0, displayBlank);
    sleepOutMode = 1'b1;
    base = lfsr(base);
    expQ.push_back('{base, 1'b0});
    blankCnt = 0;
    pulse(1000, -1);
    sleepOutMode = 1'b0;
    chk_bit("blankLen", 1'b1, blankCnt >= BLK - 1 && blankCnt <= BLK);
    wait_ready(COUT + 4);
    chk_bit("slpOutEarly", 1'b0, sleepOutOk);
    while (sleepOutOk !== 1'b1 && waited < SLP + 10)
    begin
      step;
      waited++;
    end
    chk_bit("slpOutWait", 1'b1, waited >= SLP && sleepOutOk === 1'b1);
    lat = 9'd250;
    base = lfsr(base);
    expQ.push_back('{base, 1'b1});
    pulse(1000, -1);
    wait_ready(CIN + 4);
    chk_bit("cancelLen", 1'b1, waited >= CIN);
    step;
    chk_bit("allSeen", 1'b1, expQ.size() == 0);
    finish_test;
  end
endmodule // tb
